/* File: core/scps_pkg.sv */
// constants and types shared by the system clock pwm generator
package scps_pkg;

	//////////////////////////////////////////////////////////////////////
	// register byte offsets on the apb
	localparam logic [7:0] SCPS_OFF_ROLE   = 8'h00;
	localparam logic [7:0] SCPS_OFF_TIMER  = 8'h04;
	localparam logic [7:0] SCPS_OFF_LIMIT  = 8'h08;
	localparam logic [7:0] SCPS_OFF_DUTY   = 8'h0c;
	localparam logic [7:0] SCPS_OFF_PHASE  = 8'h10;
	localparam logic [7:0] SCPS_OFF_STATUS = 8'h14;

	//////////////////////////////////////////////////////////////////////
	// values after reset
	localparam logic [7:0] SCPS_RST_ROLE  = 8'h00;
	localparam logic [7:0] SCPS_RST_TIMER = 8'h00;
	localparam logic [7:0] SCPS_RST_LIMIT = 8'h00;
	localparam logic [7:0] SCPS_RST_DUTY  = 8'h00;
	localparam logic [7:0] SCPS_RST_PHASE = 8'h00;

	//////////////////////////////////////////////////////////////////////
	// field positions
	localparam int SCPS_ROLE_LSB = 6;
	localparam int SCPS_RUN_BIT  = 2;
	localparam int SCPS_PS_LSB   = 0;
	localparam int SCPS_ST_DUTY  = 8;
	localparam int SCPS_ST_PHASE = 16;
	localparam int SCPS_ST_CLK   = 24;
	localparam int SCPS_ST_ALIGN = 25;

	// sync_role_select codes
	localparam logic [1:0] SCPS_ROLE_ALONE  = 2'h0;
	localparam logic [1:0] SCPS_ROLE_MASTER = 2'h1;
	localparam logic [1:0] SCPS_ROLE_SLAVE  = 2'h2;

	// counter_prescale_select codes and last prescaler counts
	localparam logic [1:0] SCPS_PS_DIV1 = 2'h0;
	localparam logic [1:0] SCPS_PS_DIV4 = 2'h1;
	localparam logic [3:0] SCPS_LAST_DIV1  = 4'h0;
	localparam logic [3:0] SCPS_LAST_DIV4  = 4'h3;
	localparam logic [3:0] SCPS_LAST_DIV16 = 4'hf;

	typedef enum logic [1:0] {
		SCPS_FREE  = 2'b01,
		SCPS_ALIGN = 2'b10
	} scps_align_t;

endpackage

/* File: core/scps_prescale.sv */
// period counter prescaler: one tick every 1, 4 or 16 clocks
`timescale 1ns/1ps
module scps_prescale (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       run,
	input  wire logic [1:0] sel,
	output logic            tick
);

	typedef struct packed {
		logic [3:0] cnt;
	} scps_ps_state_t;

	scps_ps_state_t st_r;
	scps_ps_state_t st_nxt;
	logic [3:0]     last;

	//////////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt = st_r;
		case (sel)
			scps_pkg::SCPS_PS_DIV1: last = scps_pkg::SCPS_LAST_DIV1;
			scps_pkg::SCPS_PS_DIV4: last = scps_pkg::SCPS_LAST_DIV4;
			default:                last = scps_pkg::SCPS_LAST_DIV16;
		endcase
		// >= covers a select change that leaves cnt beyond the new end
		tick = run && (st_r.cnt >= last);
		if (run) begin
			st_nxt.cnt = tick ? 4'h0 : st_r.cnt + 4'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	//////////////////////////////////////////////////////////////////////
	a_div16_gap: assert property (@(posedge pclk) disable iff (!presetn)
		(tick && run && sel == 2'h2) ##1 (run && sel == 2'h2)[*8] |-> !tick)
		else $error("prescaler ticked early at divide by 16");

	a_stop_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!run |-> !tick ##1 $stable(st_r.cnt))
		else $error("prescaler moved while stopped");

endmodule

/* File: core/scps_core.sv */
// system clock pwm generator with master/slave sync and apb registers
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
module scps_core (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sleep,
	input  wire logic        sync_pin_in,
	output logic             sync_pin_out,
	output logic             sync_pin_oe_n,
	output logic             clock_out_pin
);

	typedef struct packed {
		logic [7:0]            sync_role_control;
		logic [7:0]            period_timer_control;
		logic [7:0]            period_limit;
		logic [7:0]            duty_buffer;
		logic [7:0]            phase_buffer;
		logic [7:0]            period_counter;
		logic [7:0]            duty_active;
		logic [7:0]            phase_active;
		logic [7:0]            phase_left;
		scps_pkg::scps_align_t align;
		logic                  clk_out;
		logic                  sync_s1;
		logic                  sync_s2;
		logic                  sync_s3;
		logic [31:0]           rdata;
	} scps_state_t;

	scps_state_t st_r;
	scps_state_t st_nxt;

	logic [1:0]  sync_role_select;
	logic        counter_run;
	logic [1:0]  counter_prescale_select;
	logic        run;
	logic        tick;
	logic        match;
	logic        master_edge;
	logic        load_evt;
	logic        mapped;
	logic        wr_en;
	logic [31:0] rd_mux;

	assign sync_role_select =
		st_r.sync_role_control[scps_pkg::SCPS_ROLE_LSB +: 2];
	assign counter_run =
		st_r.period_timer_control[scps_pkg::SCPS_RUN_BIT];
	assign counter_prescale_select =
		st_r.period_timer_control[scps_pkg::SCPS_PS_LSB +: 2];
	// sleep stops the time base without touching any setting
	assign run = counter_run && !sleep;

	//////////////////////////////////////////////////////////////////////
	scps_prescale u_prescale (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (run),
		.sel     (counter_prescale_select),
		.tick    (tick)
	);

	assign match = tick && (st_r.period_counter == st_r.period_limit);
	// only the synchronised copy is edge-detected
	assign master_edge = st_r.sync_s2 && !st_r.sync_s3 && !sleep
		&& (sync_role_select == scps_pkg::SCPS_ROLE_SLAVE);
	assign load_evt = match || master_edge;

	//////////////////////////////////////////////////////////////////////
	// apb slave: no wait states, read data captured in the setup cycle
	assign pready = 1'b1;
	assign mapped = (paddr[1:0] == 2'h0)
		&& (paddr <= scps_pkg::SCPS_OFF_STATUS);
	assign pslverr = psel && penable && !mapped;
	assign wr_en = psel && penable && pwrite && mapped;
	assign prdata = st_r.rdata;

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (paddr)
			scps_pkg::SCPS_OFF_ROLE: begin
				rd_mux[7:0] = st_r.sync_role_control;
			end
			scps_pkg::SCPS_OFF_TIMER: begin
				rd_mux[7:0] = st_r.period_timer_control;
			end
			scps_pkg::SCPS_OFF_LIMIT: begin
				rd_mux[7:0] = st_r.period_limit;
			end
			scps_pkg::SCPS_OFF_DUTY: begin
				rd_mux[7:0] = st_r.duty_buffer;
			end
			scps_pkg::SCPS_OFF_PHASE: begin
				rd_mux[7:0] = st_r.phase_buffer;
			end
			scps_pkg::SCPS_OFF_STATUS: begin
				rd_mux[7:0] = st_r.period_counter;
				rd_mux[scps_pkg::SCPS_ST_DUTY +: 8] = st_r.duty_active;
				rd_mux[scps_pkg::SCPS_ST_PHASE +: 8] = st_r.phase_active;
				rd_mux[scps_pkg::SCPS_ST_CLK] = st_r.clk_out;
				rd_mux[scps_pkg::SCPS_ST_ALIGN] =
					(st_r.align == scps_pkg::SCPS_ALIGN);
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	//////////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt = st_r;
		st_nxt.sync_s1 = sync_pin_in;
		st_nxt.sync_s2 = st_r.sync_s1;
		st_nxt.sync_s3 = st_r.sync_s2;
		if (psel && !penable) begin
			st_nxt.rdata = rd_mux;
		end
		// buffers accept writes at any time, even in sleep
		if (wr_en) begin
			case (paddr)
				scps_pkg::SCPS_OFF_ROLE: begin
					st_nxt.sync_role_control = pwdata[7:0] & 8'hc8;
				end
				scps_pkg::SCPS_OFF_TIMER: begin
					st_nxt.period_timer_control = pwdata[7:0] & 8'h07;
				end
				scps_pkg::SCPS_OFF_LIMIT: begin
					st_nxt.period_limit = pwdata[7:0];
				end
				scps_pkg::SCPS_OFF_DUTY: begin
					st_nxt.duty_buffer = pwdata[7:0];
				end
				scps_pkg::SCPS_OFF_PHASE: begin
					st_nxt.phase_buffer = pwdata[7:0];
				end
				default: begin
					st_nxt.rdata = st_r.rdata;
				end
			endcase
		end
		// pwm time base; there is no capture path at all
		if (tick) begin
			if (match) begin
				st_nxt.period_counter = 8'h00;
			end else begin
				st_nxt.period_counter = st_r.period_counter + 8'h01;
			end
		end
		// the active duty changes only here, never per cycle by software
		if (load_evt) begin
			st_nxt.duty_active = st_r.duty_buffer;
			st_nxt.phase_active = st_r.phase_buffer;
		end
		// slave start point trails the master edge by phase ticks
		if (master_edge) begin
			if (st_r.phase_buffer == 8'h00) begin
				st_nxt.period_counter = 8'h00;
				st_nxt.align = scps_pkg::SCPS_FREE;
			end else begin
				st_nxt.phase_left = st_r.phase_buffer;
				st_nxt.align = scps_pkg::SCPS_ALIGN;
			end
		end else begin
			case (st_r.align)
				scps_pkg::SCPS_FREE: begin
					st_nxt.align = scps_pkg::SCPS_FREE;
				end
				scps_pkg::SCPS_ALIGN: begin
					if (tick) begin
						if (st_r.phase_left == 8'h01) begin
							st_nxt.period_counter = 8'h00;
							st_nxt.align = scps_pkg::SCPS_FREE;
						end else begin
							st_nxt.phase_left = st_r.phase_left - 8'h01;
						end
					end
				end
				default: begin
					st_nxt.align = scps_pkg::SCPS_FREE;
				end
			endcase
		end
		// output level follows the new count; frozen while not running
		if (run) begin
			st_nxt.clk_out =
				(st_nxt.period_counter < st_nxt.duty_active);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
			st_r.sync_role_control <= scps_pkg::SCPS_RST_ROLE;
			st_r.period_timer_control <= scps_pkg::SCPS_RST_TIMER;
			st_r.period_limit <= scps_pkg::SCPS_RST_LIMIT;
			st_r.duty_buffer <= scps_pkg::SCPS_RST_DUTY;
			st_r.phase_buffer <= scps_pkg::SCPS_RST_PHASE;
			st_r.align <= scps_pkg::SCPS_FREE;
		end else begin
			st_r <= st_nxt;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// the pwm wave is the system clock, also driven out by a master
	assign clock_out_pin = st_r.clk_out;
	assign sync_pin_out = st_r.clk_out;
	assign sync_pin_oe_n =
		(sync_role_select != scps_pkg::SCPS_ROLE_MASTER);

	//////////////////////////////////////////////////////////////////////
	a_match_wrap: assert property (@(posedge pclk)
		disable iff (!presetn)
		match && !master_edge |=> st_r.period_counter == 8'h00)
		else $error("counter not cleared after limit match");

	a_duty_load: assert property (@(posedge pclk)
		disable iff (!presetn)
		match |=> st_r.duty_active == $past(st_r.duty_buffer))
		else $error("duty not loaded on match");

	a_duty_hold: assert property (@(posedge pclk)
		disable iff (!presetn)
		!load_evt |=> $stable(st_r.duty_active))
		else $error("active duty changed without load event");

	a_count_step: assert property (@(posedge pclk)
		disable iff (!presetn)
		tick && !match && st_r.align == scps_pkg::SCPS_FREE && !master_edge
		|=> st_r.period_counter == $past(st_r.period_counter) + 8'h01)
		else $error("counter did not advance by one");

	a_sleep_freeze: assert property (@(posedge pclk)
		disable iff (!presetn)
		sleep |=> $stable(st_r.period_counter) && $stable(clock_out_pin)
			&& $stable(st_r.duty_active))
		else $error("state moved during sleep");

	a_out_level: assert property (@(posedge pclk)
		disable iff (!presetn)
		run |=> clock_out_pin ==
			(st_r.period_counter < st_r.duty_active))
		else $error("output level disagrees with count and duty");

	a_master_drive: assert property (@(posedge pclk)
		disable iff (!presetn)
		sync_role_select == scps_pkg::SCPS_ROLE_MASTER
		|-> !sync_pin_oe_n && sync_pin_out == clock_out_pin)
		else $error("master not driving sync pin");

	a_slave_load: assert property (@(posedge pclk)
		disable iff (!presetn)
		master_edge |=> st_r.phase_active == $past(st_r.phase_buffer)
			&& st_r.duty_active == $past(st_r.duty_buffer))
		else $error("sync edge did not load buffers");

	a_no_run_hold: assert property (@(posedge pclk)
		disable iff (!presetn)
		!counter_run && !master_edge && st_r.align == scps_pkg::SCPS_FREE
		|=> $stable(st_r.period_counter))
		else $error("counter advanced without run bit");

	// the slave period restarts on the last tick of the phase offset
	a_align_restart: assert property (@(posedge pclk)
		disable iff (!presetn)
		st_r.align == scps_pkg::SCPS_ALIGN && tick && !master_edge
		&& st_r.phase_left == 8'h01 |=> st_r.period_counter == 8'h00)
		else $error("slave did not restart after phase offset");

	c_match: cover property (@(posedge pclk) disable iff (!presetn)
		match && counter_prescale_select == scps_pkg::SCPS_PS_DIV4);
	c_slave_edge: cover property (@(posedge pclk) disable iff (!presetn)
		master_edge && st_r.phase_buffer != 8'h00);
	c_align_done: cover property (@(posedge pclk) disable iff (!presetn)
		st_r.align == scps_pkg::SCPS_ALIGN ##1
		st_r.align == scps_pkg::SCPS_FREE);
	c_sleep_wake: cover property (@(posedge pclk) disable iff (!presetn)
		counter_run && sleep ##1 !sleep);
	c_master_role: cover property (@(posedge pclk) disable iff (!presetn)
		sync_role_select == scps_pkg::SCPS_ROLE_MASTER && match);

endmodule

/* File: test/scps_peer.sv */
// far-side converter acting as sync master on the shared sync pin
`timescale 1ns/1ps
module scps_peer #(
	parameter int PER = 400,
	parameter int HI  = 200
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic present,
	input  wire logic run,
	output logic      clk_o,
	output logic      oe_n
);
	int cnt;
	// a master drives the pin all the time, so the pull-up never fakes an edge
	assign oe_n = !present;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			clk_o <= 1'b0;
		end else if (!run) begin
			cnt <= 0;
			clk_o <= 1'b0;
		end else begin
			clk_o <= cnt < HI;
			cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
		end
	end
endmodule

/* File: test/testbench.sv */
// self-checking bench for the system clock pwm generator
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; \
	$display("unexpected at %0t: got %h exp %h", $time, (a), (e)); end end
module testbench;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, s;
	logic        pready, pslverr, err, sleep = 0, sync_wire, sync_pin_out;
	logic        sync_pin_oe_n, clock_out_pin, peer_clk, peer_oe_n;
	logic        peer_present = 0, peer_run = 0;
	int          failures = 0, n_tests = 0, hi, lo, d0, d1, mism;

	always #10 pclk = ~pclk;
	// pull-up on the sync pin when nobody drives it
	assign sync_wire = !sync_pin_oe_n ? sync_pin_out :
		(!peer_oe_n ? peer_clk : 1'b1);
	scps_core dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .sleep,
		.sync_pin_in(sync_wire), .sync_pin_out, .sync_pin_oe_n,
		.clock_out_pin);
	scps_peer peer (.pclk, .presetn, .present(peer_present), .run(peer_run),
		.clk_o(peer_clk), .oe_n(peer_oe_n));

	//////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("failures=%0d n_tests=%0d", failures, n_tests);
		if (failures == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// entered just after a rising edge, leaves one edge after release
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd, e)
		`CHK(err, 1'b0)
	endtask
	task automatic wait_lvl(input logic v);
		while (clock_out_pin !== v) @(posedge pclk);
	endtask
	// one full period from a rising edge of the output
	task automatic measure();
		wait_lvl(1'b0);
		wait_lvl(1'b1);
		hi = 0;
		lo = 0;
		while (clock_out_pin === 1'b1) begin @(posedge pclk); hi++; end
		while (clock_out_pin === 1'b0) begin @(posedge pclk); lo++; end
	endtask

	//////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		for (int a = 0; a <= 20; a += 4) chk_rd(a[7:0], 32'h0);
		wr(scps_pkg::SCPS_OFF_ROLE, 32'hffff_ffff);
		chk_rd(scps_pkg::SCPS_OFF_ROLE, 32'h0000_00c8);
		wr(scps_pkg::SCPS_OFF_TIMER, 32'hffff_fffb);
		chk_rd(scps_pkg::SCPS_OFF_TIMER, 32'h0000_0003);
		for (int a = 8; a <= 16; a += 4) begin
			wr(a[7:0], 32'h1234_56a5);
			chk_rd(a[7:0], 32'h0000_00a5);
		end
		apb(1'b0, 8'h18, 32'h0);
		`CHK({err, rd}, {1'b1, 32'h0})
		apb(1'b1, 8'h0a, 32'h77);
		`CHK(err, 1'b1)
		chk_rd(scps_pkg::SCPS_OFF_LIMIT, 32'h0000_00a5);
		wr(scps_pkg::SCPS_OFF_ROLE, 32'h0);
	endtask
	task automatic t_pwm();
		int n [4] = '{1, 4, 16, 16};
		wr(scps_pkg::SCPS_OFF_LIMIT, 32'h4);
		wr(scps_pkg::SCPS_OFF_DUTY, 32'h2);
		for (int p = 0; p < 4; p++) begin
			wr(scps_pkg::SCPS_OFF_TIMER, 32'h4 | p);
			measure();
			measure();
			`CHK(hi, 2 * n[p])
			`CHK(hi + lo, 5 * n[p])
		end
		// new duty written mid-high must wait for the next match
		wr(scps_pkg::SCPS_OFF_DUTY, 32'h3);
		apb(1'b0, scps_pkg::SCPS_OFF_STATUS, 32'h0);
		`CHK(rd[15:8], 8'h02)
		measure();
		`CHK(hi, 48)
		`CHK(lo, 32)
	endtask
	task automatic t_sleep();
		wr(scps_pkg::SCPS_OFF_LIMIT, 32'hc8);
		wr(scps_pkg::SCPS_OFF_DUTY, 32'h64);
		wr(scps_pkg::SCPS_OFF_TIMER, 32'h4);
		sleep <= 1'b1;
		apb(1'b0, scps_pkg::SCPS_OFF_STATUS, 32'h0);
		s = rd;
		repeat (40) @(posedge pclk);
		chk_rd(scps_pkg::SCPS_OFF_STATUS, s);
		`CHK(clock_out_pin, s[24])
		sleep <= 1'b0;
		repeat (10) @(posedge pclk);
		apb(1'b0, scps_pkg::SCPS_OFF_STATUS, 32'h0);
		`CHK(rd[7:0] != s[7:0], 1'b1)
		wr(scps_pkg::SCPS_OFF_TIMER, 32'h0);
		apb(1'b0, scps_pkg::SCPS_OFF_STATUS, 32'h0);
		s = rd;
		repeat (20) @(posedge pclk);
		chk_rd(scps_pkg::SCPS_OFF_STATUS, s);
	endtask
	task automatic t_roles();
		logic [7:0] code [4] = '{8'h00, 8'h40, 8'h80, 8'hc0};
		wr(scps_pkg::SCPS_OFF_TIMER, 32'h4);
		for (int i = 0; i < 4; i++) begin
			wr(scps_pkg::SCPS_OFF_ROLE, {24'h0, code[i]});
			`CHK(sync_pin_oe_n, i != 1)
		end
		wr(scps_pkg::SCPS_OFF_ROLE, 32'h40);
		mism = 0;
		repeat (300) begin
			@(posedge pclk);
			mism += (sync_wire !== clock_out_pin);
		end
		`CHK(mism, 0)
	endtask
	task automatic slave_delay(input logic [7:0] p, input logic [7:0] dv,
		output int d);
		wait_lvl(1'b1);
		wait_lvl(1'b0);
		wr(scps_pkg::SCPS_OFF_PHASE, {24'h0, p});
		wr(scps_pkg::SCPS_OFF_DUTY, {24'h0, dv});
		peer_run <= 1'b1;
		@(posedge pclk);
		while (sync_wire !== 1'b1) @(posedge pclk);
		d = 0;
		while (clock_out_pin !== 1'b1) begin @(posedge pclk); d++; end
		peer_run <= 1'b0;
		apb(1'b0, scps_pkg::SCPS_OFF_STATUS, 32'h0);
		`CHK(rd[23:8], {p, dv})
	endtask
	task automatic t_slave();
		// leave the master role before the peer drives: no stray sync edge
		wr(scps_pkg::SCPS_OFF_ROLE, 32'h0);
		peer_present <= 1'b1;
		wr(scps_pkg::SCPS_OFF_ROLE, 32'h80);
		wr(scps_pkg::SCPS_OFF_DUTY, 32'ha);
		slave_delay(8'h00, 8'h0a, d0);
		slave_delay(8'h06, 8'h0c, d1);
		`CHK(d1 - d0, 6)
	endtask
	// reset in mid-run must clear the live generator state
	task automatic t_reset();
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		`CHK({clock_out_pin, sync_pin_oe_n, prdata}, {2'b01, 32'h0})
		presetn <= 1'b1;
		@(posedge pclk);
		chk_rd(scps_pkg::SCPS_OFF_STATUS, 32'h0);
		chk_rd(scps_pkg::SCPS_OFF_DUTY, {24'h0, scps_pkg::SCPS_RST_DUTY});
	endtask

	//////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_pwm();
		t_sleep();
		t_roles();
		t_slave();
		t_reset();
		print_verdict();
	end
	// the whole sequence needs a few thousand cycles
	initial begin
		repeat (30000) @(posedge pclk);
		failures++;
		print_verdict();
	end
endmodule
